// ---- verilog/irt_timer_pair.sv ----
// Purpose: 8-bit and 16-bit down counter pair with transmit and demodulation modes.
// Assumes: APB slave, zero wait states; timer tick is every pclk edge.
// Notes: Long capture and reload follow every selected demodulation edge while the long counter is enabled.
// Behaviour
// - Demodulation: short count goes to high or low capture by input level.
// - Long counter capture splits into MS byte and LS byte registers.
// - Capture mask set: interrupt on every short counter capture.
// - Counter mask set: interrupt on short counter timeout.
// - Control bit picks port value or short output for its pin.
// - Common bit 7 picks transmit (0, default) or demodulation (1).
// - Common bit 6: transmit output routing, or demodulation input pin choice.
// - Transmit: bits 5:4 combine outputs as AND, OR, NOR, NAND.
// - Demodulation: bits 5:4 pick falling, rising, both edges; 11 reserved.
// - Long counter disabled, normal or alternating: output is inverse initial value.
// - Bits 3:2 at 10 or 11 force long output to 0 or 1.
// - Long enable loads high hold times 256 plus low hold, output initial.
// - Long zero: toggle output (transmit only), set timeout status, interrupt if enabled.
// - Long terminal: transmit single-pass stops, modulo-N reloads; demodulation wraps and counts on.
// - Hold bytes writable anytime; used only at the next load.
`timescale 1ns/100ps
module irt_timer_pair #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_edge_input_pin,
  input wire logic second_edge_input_pin,
  input wire logic short_pin_port_value,
  input wire logic combined_pin_port_value,
  output logic short_pin_out,
  output logic combined_pin_out,
  output logic long_counter_output,
  output logic timer_irq
);

  localparam int SW = irt_pkg::SHORT_W;
  localparam int LW = irt_pkg::LONG_W;

  // Address decode needs index bits 5:2 plus at least one bit above
  if (ADDR_W < 7 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie in 7..32");
  end

  // Software state
  logic t8_en_q, t8_en_d;
  logic t8_modn_q, t8_capmask_q, t8_cntmask_q, t8_pinsel_q;
  logic t16_en_q, t16_en_d;
  logic t16_modn_q, t16_toint_q;
  logic [7:0] common_q, aux_q;
  logic [7:0] hold8l_q, hold8h_q, hold16l_q, hold16h_q;
  logic [7:0] cap8l_q, cap8h_q, cap16l_q, cap16h_q;
  logic [irt_pkg::IRQ_W-1:0] irq_stat_q, irq_en_q, irq_set;
  logic [31:0] prdata_q;
  logic slverr_q;

  // Counter state
  logic [SW-1:0] cnt8_q, cnt8_d;
  logic [LW-1:0] cnt16_q, cnt16_d;
  logic out8_q, out8_d, out16_q, out16_d;
  logic t8_tc, t16_tc;

  // APB decode
  logic [irt_pkg::IDX_W-1:0] idx;
  logic mapped, wr_en;
  logic [irt_pkg::NREG-1:0] wr_hit;
  logic [7:0] rd_arr [irt_pkg::NREG];
  logic [7:0] wbyte;

  assign idx = paddr[5:2];
  assign mapped = (paddr[ADDR_W-1:6] == '0) && (paddr[1:0] == 2'h0)
                  && irt_pkg::MAP_MASK[idx];
  assign wr_en = psel & penable & pwrite & mapped;
  assign wbyte = pwdata[7:0];
  // No wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = penable & slverr_q;
  assign prdata = prdata_q;

  // One write strobe per register index
  for (genvar i = 0; i < irt_pkg::NREG; i++) begin : g_wr
    assign wr_hit[i] = wr_en & (idx == irt_pkg::IDX_W'(i));
  end

  // Mode and field views of the common control
  logic demod, sel_bit;
  logic [1:0] fn_bits, oc_bits;
  logic init8, init16, pingpong, forced;

  assign demod = common_q[irt_pkg::COM_MODE];
  assign sel_bit = common_q[irt_pkg::COM_SEL];
  assign fn_bits = common_q[irt_pkg::COM_FN_HI:irt_pkg::COM_FN_LO];
  assign oc_bits = common_q[irt_pkg::COM_OC_HI:irt_pkg::COM_OC_LO];
  assign init8 = common_q[irt_pkg::COM_INIT8];
  assign init16 = common_q[irt_pkg::COM_INIT16];
  assign pingpong = ~demod & (oc_bits == irt_pkg::OUT_PINGPONG);
  assign forced = oc_bits[1];

  // Demodulation input edges
  logic edge_hit, was_high, cap_evt;

  irt_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .first_pin(first_edge_input_pin),
    .second_pin(second_edge_input_pin),
    .pin_sel(sel_bit),
    .edge_sel(fn_bits),
    .edge_hit(edge_hit),
    .was_high(was_high)
  );

  assign cap_evt = demod & t8_en_q & edge_hit;

  // Starts: software enable from idle, or hand-over between the pair
  logic sw_t8, sw_t16, start8, start16;
  assign sw_t8 = wr_hit[irt_pkg::IDX_T8_CTL];
  assign sw_t16 = wr_hit[irt_pkg::IDX_T16_CTL];
  // Hand-over only while alternating; writing 00 to bits 3:2 stops it
  assign start8 = (sw_t8 & wbyte[irt_pkg::CTL_EN] & ~t8_en_q)
                  | (pingpong & t16_tc & ~t16_modn_q);
  assign start16 = (sw_t16 & wbyte[irt_pkg::CTL_EN] & ~t16_en_q)
                   | (pingpong & t8_tc & ~t8_modn_q);

  // Short counter next state; hold bytes read only at a load
  always_comb begin
    cnt8_d = cnt8_q;
    out8_d = out8_q;
    t8_en_d = t8_en_q;
    t8_tc = 1'b0;
    if (start8) begin
      out8_d = init8;
      cnt8_d = init8 ? hold8h_q : hold8l_q;
      t8_en_d = 1'b1;
    end else if (t8_en_q) begin
      if (cap_evt) begin
        cnt8_d = was_high ? hold8l_q : hold8h_q;
      end else if (cnt8_q == {SW{1'b0}}) begin
        t8_tc = 1'b1;
        out8_d = demod ? out8_q : ~out8_q;
        if (t8_modn_q) begin
          cnt8_d = out8_d ? hold8h_q : hold8l_q;
        end else begin
          t8_en_d = 1'b0;
        end
      end else begin
        cnt8_d = cnt8_q - 1'b1;
      end
    end
    // Software disable wins over a running count
    if (sw_t8 && !wbyte[irt_pkg::CTL_EN]) begin
      t8_en_d = 1'b0;
    end
  end

  // Long counter next state
  always_comb begin
    cnt16_d = cnt16_q;
    out16_d = out16_q;
    t16_en_d = t16_en_q;
    t16_tc = 1'b0;
    if (start16) begin
      cnt16_d = {hold16h_q, hold16l_q};
      out16_d = init16;
      t16_en_d = 1'b1;
    end else if (t16_en_q) begin
      if (demod && edge_hit) begin
        cnt16_d = {hold16h_q, hold16l_q};
      end else if (cnt16_q == {LW{1'b0}}) begin
        t16_tc = 1'b1;
        out16_d = demod ? out16_q : ~out16_q;
        if (demod) begin
          cnt16_d = cnt16_q - 1'b1;
        end else if (t16_modn_q) begin
          cnt16_d = {hold16h_q, hold16l_q};
        end else begin
          t16_en_d = 1'b0;
        end
      end else begin
        cnt16_d = cnt16_q - 1'b1;
      end
    end
    if (sw_t16 && !wbyte[irt_pkg::CTL_EN]) begin
      t16_en_d = 1'b0;
    end
  end

  // Counters and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt8_q <= {SW{1'b0}};
      cnt16_q <= {LW{1'b0}};
      out8_q <= 1'b0;
      out16_q <= 1'b0;
      t8_en_q <= 1'b0;
      t16_en_q <= 1'b0;
    end else begin
      cnt8_q <= cnt8_d;
      cnt16_q <= cnt16_d;
      out8_q <= out8_d;
      out16_q <= out16_d;
      t8_en_q <= t8_en_d;
      t16_en_q <= t16_en_d;
    end
  end

  // Control registers; enable bits live with the counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t8_modn_q <= 1'b0;
      t8_capmask_q <= 1'b0;
      t8_cntmask_q <= 1'b0;
      t8_pinsel_q <= 1'b0;
      t16_modn_q <= 1'b0;
      t16_toint_q <= 1'b0;
      common_q <= irt_pkg::RST_BYTE;
      aux_q <= irt_pkg::RST_BYTE;
    end else begin
      if (sw_t8) begin
        t8_modn_q <= wbyte[irt_pkg::CTL_MODN];
        t8_capmask_q <= wbyte[irt_pkg::CTL_CAPMASK];
        t8_cntmask_q <= wbyte[irt_pkg::CTL_CNTMASK];
        t8_pinsel_q <= wbyte[irt_pkg::CTL_PINSEL];
      end
      if (sw_t16) begin
        t16_modn_q <= wbyte[irt_pkg::CTL_MODN];
        t16_toint_q <= wbyte[irt_pkg::CTL_TOINT];
      end
      if (wr_hit[irt_pkg::IDX_COMMON]) common_q <= wbyte;
      if (wr_hit[irt_pkg::IDX_AUX]) aux_q <= wbyte;
    end
  end

  // Hold bytes: plain storage, never touch a running count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold8l_q <= irt_pkg::RST_BYTE;
      hold8h_q <= irt_pkg::RST_BYTE;
      hold16l_q <= irt_pkg::RST_BYTE;
      hold16h_q <= irt_pkg::RST_BYTE;
    end else begin
      if (wr_hit[irt_pkg::IDX_T8_LO_HOLD]) hold8l_q <= wbyte;
      if (wr_hit[irt_pkg::IDX_T8_HI_HOLD]) hold8h_q <= wbyte;
      if (wr_hit[irt_pkg::IDX_T16_LO_HOLD]) hold16l_q <= wbyte;
      if (wr_hit[irt_pkg::IDX_T16_HI_HOLD]) hold16h_q <= wbyte;
    end
  end

  // Captures; software writes to these have no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap8l_q <= irt_pkg::RST_BYTE;
      cap8h_q <= irt_pkg::RST_BYTE;
      cap16l_q <= irt_pkg::RST_BYTE;
      cap16h_q <= irt_pkg::RST_BYTE;
    end else begin
      if (cap_evt && was_high) cap8h_q <= cnt8_q;
      if (cap_evt && !was_high) cap8l_q <= cnt8_q;
      if (demod && t16_en_q && edge_hit) begin
        cap16h_q <= cnt16_q[LW-1:8];
        cap16l_q <= cnt16_q[7:0];
      end
    end
  end

  // Sticky status; a set in the clear cycle survives
  assign irq_set[irt_pkg::IRQ_T8] = t8_tc;
  assign irq_set[irt_pkg::IRQ_CAP] = cap_evt;
  assign irq_set[irt_pkg::IRQ_T16] = t16_tc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= {irt_pkg::IRQ_W{1'b0}};
      irq_en_q <= {irt_pkg::IRQ_W{1'b0}};
    end else begin
      irq_stat_q <= irq_set | (irq_stat_q
                    & ~({irt_pkg::IRQ_W{wr_hit[irt_pkg::IDX_IRQ_CLR]}}
                    & wbyte[irt_pkg::IRQ_W-1:0]));
      if (wr_hit[irt_pkg::IDX_IRQ_EN]) irq_en_q <= wbyte[irt_pkg::IRQ_W-1:0];
    end
  end

  // Interrupt line: enable register and per-source mask both needed
  logic [irt_pkg::IRQ_W-1:0] src_mask;
  assign src_mask[irt_pkg::IRQ_T8] = t8_cntmask_q;
  assign src_mask[irt_pkg::IRQ_CAP] = t8_capmask_q;
  assign src_mask[irt_pkg::IRQ_T16] = t16_toint_q;
  assign timer_irq = ~aux_q[irt_pkg::AUX_GDIS]
                     & (|(irq_stat_q & irq_en_q & src_mask));

  // Long output: forced codes override, idle shows inverse initial value
  logic long_out, comb_out;
  assign long_out = forced ? oc_bits[0] :
                    (t16_en_q ? out16_q : ~init16);
  assign long_counter_output = long_out;

  // Combined output logic
  assign comb_out = (fn_bits == irt_pkg::LOGIC_AND) ? (out8_q & long_out) :
                    (fn_bits == irt_pkg::LOGIC_OR) ? (out8_q | long_out) :
                    (fn_bits == irt_pkg::LOGIC_NOR) ? ~(out8_q | long_out) :
                    ~(out8_q & long_out);

  // Pin routing; demodulation returns the combined pin to the port
  assign combined_pin_out = (~demod & sel_bit) ? comb_out
                            : combined_pin_port_value;
  assign short_pin_out = t8_pinsel_q ? out8_q : short_pin_port_value;

  // Read view, unused bits read as zero except in the auxiliary byte, which reads back as written
  assign rd_arr[irt_pkg::IDX_T8_CTL] = {t8_en_q, t8_modn_q,
    irq_stat_q[irt_pkg::IRQ_T8], 2'h0, t8_capmask_q, t8_cntmask_q, t8_pinsel_q};
  assign rd_arr[irt_pkg::IDX_COMMON] = common_q;
  assign rd_arr[irt_pkg::IDX_T16_CTL] = {t16_en_q, t16_modn_q,
    irq_stat_q[irt_pkg::IRQ_T16], 3'h0, t16_toint_q, 1'b0};
  assign rd_arr[irt_pkg::IDX_AUX] = aux_q;
  assign rd_arr[irt_pkg::IDX_T8_LO_HOLD] = hold8l_q;
  assign rd_arr[irt_pkg::IDX_T8_HI_HOLD] = hold8h_q;
  assign rd_arr[irt_pkg::IDX_T16_LO_HOLD] = hold16l_q;
  assign rd_arr[irt_pkg::IDX_T16_HI_HOLD] = hold16h_q;
  assign rd_arr[irt_pkg::IDX_C16_LO] = cap16l_q;
  assign rd_arr[irt_pkg::IDX_C16_HI] = cap16h_q;
  assign rd_arr[irt_pkg::IDX_C8_LO] = cap8l_q;
  assign rd_arr[irt_pkg::IDX_C8_HI] = cap8h_q;
  assign rd_arr[irt_pkg::IDX_IRQ_STAT] = {5'h00, irq_stat_q};
  assign rd_arr[irt_pkg::IDX_IRQ_CLR] = 8'h00; // Write-only
  assign rd_arr[irt_pkg::IDX_IRQ_EN] = {5'h00, irq_en_q};
  assign rd_arr[4'hF] = 8'h00;

  // Read data and error taken at the setup edge, so data leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= (mapped && !pwrite) ? {24'h000000, rd_arr[idx]} : 32'h00000000;
      slverr_q <= ~mapped;
    end
  end

endmodule

// ---- verilog/irt_pkg.sv ----
// Purpose: Shared constants and encodings of the infrared counter/timer pair.
// Assumes: Registers sit one per 32-bit APB word, byte address = index * 4.
// Notes: Register indices are the printed offsets; data sits in bits 7:0.
package irt_pkg;

  // Counter widths and register index width
  localparam int SHORT_W = 8;
  localparam int LONG_W = 16;
  localparam int IDX_W = 4;
  localparam int NREG = 16;

  // Register indices
  localparam logic [3:0] IDX_T8_CTL = 4'h0;
  localparam logic [3:0] IDX_COMMON = 4'h1;
  localparam logic [3:0] IDX_T16_CTL = 4'h2;
  localparam logic [3:0] IDX_AUX = 4'h3;
  localparam logic [3:0] IDX_T8_LO_HOLD = 4'h4;
  localparam logic [3:0] IDX_T8_HI_HOLD = 4'h5;
  localparam logic [3:0] IDX_T16_LO_HOLD = 4'h6;
  localparam logic [3:0] IDX_T16_HI_HOLD = 4'h7;
  localparam logic [3:0] IDX_C16_LO = 4'h8;
  localparam logic [3:0] IDX_C16_HI = 4'h9;
  localparam logic [3:0] IDX_C8_LO = 4'hA;
  localparam logic [3:0] IDX_C8_HI = 4'hB;
  localparam logic [3:0] IDX_IRQ_STAT = 4'hC;
  localparam logic [3:0] IDX_IRQ_CLR = 4'hD;
  localparam logic [3:0] IDX_IRQ_EN = 4'hE;
  // One bit per index that answers without error
  localparam logic [15:0] MAP_MASK = 16'h7FFF;

  // Counter control fields (short and long counter control)
  localparam int CTL_EN = 7;
  localparam int CTL_MODN = 6;
  localparam int CTL_TOUT = 5;
  localparam int CTL_CAPMASK = 2;
  localparam int CTL_CNTMASK = 1;
  localparam int CTL_PINSEL = 0;
  localparam int CTL_TOINT = 1;

  // Common control fields
  localparam int COM_MODE = 7;
  localparam int COM_SEL = 6;
  localparam int COM_FN_HI = 5;
  localparam int COM_FN_LO = 4;
  localparam int COM_OC_HI = 3;
  localparam int COM_OC_LO = 2;
  localparam int COM_INIT8 = 1;
  localparam int COM_INIT16 = 0;

  // Auxiliary control: global interrupt disable
  localparam int AUX_GDIS = 0;

  // Interrupt status, clear and enable layout
  localparam int IRQ_W = 3;
  localparam int IRQ_T8 = 0;
  localparam int IRQ_CAP = 1;
  localparam int IRQ_T16 = 2;

  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [1:0] {
    LOGIC_AND = 2'b00,
    LOGIC_OR = 2'b01,
    LOGIC_NOR = 2'b10,
    LOGIC_NAND = 2'b11
  } irt_logic_t;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_RSVD = 2'b11
  } irt_edge_t;

  typedef enum logic [1:0] {
    OUT_NORMAL = 2'b00,
    OUT_PINGPONG = 2'b01,
    OUT_FORCE0 = 2'b10,
    OUT_FORCE1 = 2'b11
  } irt_outcfg_t;

endpackage

// ---- verilog/irt_edge_detect.sv ----
// Purpose: Edge detector for the demodulation input of the counter pair.
// Assumes: Both pins are synchronous to pclk.
// Notes: The first sample after reset arms the detector and never fires.
`timescale 1ns/100ps
module irt_edge_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic first_pin,
  input wire logic second_pin,
  input wire logic pin_sel,
  input wire logic [1:0] edge_sel,
  output logic edge_hit,
  output logic was_high
);

  logic level_q;
  logic armed_q;
  logic cur;
  logic rise;
  logic fall;

  // Input choice and raw edges
  assign cur = pin_sel ? second_pin : first_pin;
  assign rise = armed_q & cur & ~level_q;
  assign fall = armed_q & ~cur & level_q;
  assign was_high = level_q;

  // Edge choice; the reserved code detects nothing
  assign edge_hit = (edge_sel == irt_pkg::EDGE_FALL) ? fall :
                    (edge_sel == irt_pkg::EDGE_RISE) ? rise :
                    (edge_sel == irt_pkg::EDGE_BOTH) ? (rise | fall) : 1'b0;

  // Previous level and arming flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      level_q <= cur;
      armed_q <= 1'b1;
    end
  end

endmodule

// ---- verification/irt_timer_pair_props.sv ----
// Purpose: Concurrent checks on the counter pair ports.
// Assumes: Zero wait state APB, register index in paddr[5:2].
// Notes: Shadows follow software writes; hardware never edits those fields.
`timescale 1ns/100ps
module irt_timer_pair_props #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic first_edge_input_pin,
  input wire logic second_edge_input_pin,
  input wire logic short_pin_port_value,
  input wire logic combined_pin_port_value,
  input wire logic short_pin_out,
  input wire logic combined_pin_out,
  input wire logic long_counter_output,
  input wire logic timer_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] com_q;
  logic c8_q;
  logic aux_q;
  // Access decode, refused addresses never update a shadow
  wire logic acc = psel && penable && pready;
  wire logic ok_adr = paddr[1:0] == 2'b00 && (paddr >> 6) == '0 && paddr[5:2] != 4'hF;
  wire logic wr = acc && pwrite && ok_adr;
  wire logic wcom = wr && paddr[5:2] == 4'h1;
  wire logic wl16 = wr && paddr[5:2] == 4'h2;
  // Shadows of software-owned control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_q <= 8'h00;
      c8_q <= 1'b0;
      aux_q <= 1'b0;
    end else if (wr) begin
      if (paddr[5:2] == 4'h1) com_q <= pwdata[7:0];
      if (paddr[5:2] == 4'h0) c8_q <= pwdata[0];
      if (paddr[5:2] == 4'h3) aux_q <= pwdata[0];
    end
  end
  a_bad_index:
    assert property (acc && paddr[5:2] == 4'hF |-> pslverr)
    else $error("index 15 not refused");
  a_good_adr:
    assert property (acc && ok_adr |-> !pslverr)
    else $error("mapped access refused");
  a_force_low:
    assert property (wcom && pwdata[3:2] == 2'b10 |=> !long_counter_output [*2])
    else $error("forced low not held");
  a_force_high:
    assert property (wcom && pwdata[3:2] == 2'b11 |-> ##1 long_counter_output ##1 long_counter_output)
    else $error("forced high not held");
  a_idle_inverse:
    assert property (wl16 && !pwdata[7] && !com_q[7] && com_q[3:2] == 2'b00
      |=> long_counter_output == !com_q[0])
    else $error("idle long output wrong");
  a_gdis_quiet:
    assert property (aux_q |-> !timer_irq)
    else $error("interrupt passed global disable");
  a_comb_port:
    assert property (com_q[7] || !com_q[6] |-> combined_pin_out == combined_pin_port_value)
    else $error("combined pin not port value");
  a_short_port:
    assert property (!c8_q |-> short_pin_out == short_pin_port_value)
    else $error("short pin not port value");
  c_irq: cover property ($rose(timer_irq));
  c_err: cover property (acc && pslverr);
  c_demod_irq: cover property (com_q[7] && timer_irq);
endmodule

bind irt_timer_pair irt_timer_pair_props #(.ADDR_W(ADDR_W)) i_irt_timer_pair_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .first_edge_input_pin(first_edge_input_pin),
  .second_edge_input_pin(second_edge_input_pin),
  .short_pin_port_value(short_pin_port_value),
  .combined_pin_port_value(combined_pin_port_value),
  .short_pin_out(short_pin_out), .combined_pin_out(combined_pin_out),
  .long_counter_output(long_counter_output), .timer_irq(timer_irq)
);

// ---- verification/irt_ir_source.sv ----
// Purpose: Infrared carrier bursts on the two demodulation pins.
// Assumes: Receiver pins idle high, as behind a pull-up.
// Notes: Second pin runs in opposite phase so it starts with a fall.
`timescale 1ns/100ps
module irt_ir_source #(
  parameter int HALF = 20
) (
  input wire logic pclk,
  input wire logic run,
  output logic first_pin,
  output logic second_pin
);
  int cnt = 0;
  logic lvl = 1'b1;
  // Toggle every HALF cycles inside a burst, park high outside
  always @(posedge pclk) begin
    cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
    if (!run) lvl <= 1'b1;
    else if (cnt == HALF - 1) lvl <= !lvl;
  end
  assign first_pin = lvl;
  assign second_pin = run ? !lvl : 1'b1;
endmodule

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench of the counter pair.
// Assumes: Zero wait state APB; byte address is index * 4.
// Notes: Each transfer queues its expectation; a monitor compares.
`timescale 1ns/100ps
module tb_top;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} irt_exp_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic spv = 1'b0;
  logic cpv = 1'b0;
  logic ir_run = 1'b0;
  logic [15:0] lfsr = 16'hF68A;
  logic [31:0] prdata;
  logic pready, pslverr, pin1, pin2, short_out, comb_out, long_out, irq;
  int num_errors = 0;
  int comparisons = 0;
  irt_exp_t expq[$];
  irt_timer_pair i_irt_timer_pair (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_edge_input_pin(pin1), .second_edge_input_pin(pin2),
    .short_pin_port_value(spv), .combined_pin_port_value(cpv),
    .short_pin_out(short_out), .combined_pin_out(comb_out),
    .long_counter_output(long_out), .timer_irq(irq)
  );
  irt_ir_source i_irt_ir_source (
    .pclk(pclk), .run(ir_run), .first_pin(pin1), .second_pin(pin2)
  );
  initial begin
    forever #5 pclk = !pclk;
  end
  // Expected combined level by the function code
  function automatic logic cmb(input logic [1:0] f, input logic a, input logic b);
    return f == 2'b00 ? a & b : f == 2'b01 ? a | b : f == 2'b10 ? !(a | b) : !(a & b);
  endfunction
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Random port values keep the pin muxes honest
  always @(posedge pclk) begin
    lfsr <= nxt(lfsr);
    spv <= lfsr[0];
    cpv <= lfsr[5];
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    int n;
    expq.push_back('{d, m, e});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, x, m, 1'b0);
  endtask
  // Bounded wait for the interrupt line, cycles counted
  task automatic wait_irq(output int n);
    n = 0;
    // Let a clear landing at this edge settle before the first look
    #1;
    while (irq !== 1'b1 && n < 600) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 600) begin
      num_errors++;
      conclude();
    end
  endtask
  // Oldest expectation is compared when a transfer completes
  always @(posedge pclk) begin
    irt_exp_t x;
    if (psel && penable && pready) begin
      x = expq.pop_front();
      chk("pslverr", {31'h0, pslverr}, {31'h0, x.e});
      if (!pwrite) chk("prdata", prdata & x.m, x.d & x.m);
    end
  end
  initial begin
    int n;
    logic [7:0] h;
    logic [7:0] fv [4];
    fv = '{8'h08, 8'h0C, 8'h01, 8'h00};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++) rd(12'(i * 4), 32'h0, 32'hFFFFFFFF);
    chk("long_idle", 32'(long_out), 32'h1);
    apb(1'b0, 12'h03C, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 12'h005, 32'h08, 32'h0, 1'b1);
    #1;
    chk("misaligned", 32'(long_out), 32'h1);
    tdone("map");
    // Force codes and idle level follow the common control
    for (int i = 0; i < 4; i++) begin
      wr(12'h004, fv[i]);
      #1;
      chk("long_out", 32'(long_out), 32'(i % 2));
    end
    for (int i = 4; i < 8; i++) begin
      h = lfsr[7:0];
      wr(12'(i * 4), h);
      rd(12'(i * 4), {24'h0, h}, 32'hFFFFFFFF);
    end
    tdone("force");
    // Single pass; hold rewritten mid count must not disturb it
    h = {5'h01, lfsr[2:0]};
    wr(12'h018, h);
    wr(12'h01C, 8'h00);
    wr(12'h038, 8'h04);
    wr(12'h008, 8'h82);
    #1;
    chk("long_init", 32'(long_out), 32'h0);
    wr(12'h018, 8'h40);
    wait_irq(n);
    // N+1 edges from the load, three of them spent in the hold rewrite
    chk("long_period", 32'(n), 32'(h) - 32'h2);
    chk("long_toggle", 32'(long_out), 32'h1);
    rd(12'h030, 32'h4, 32'h4);
    rd(12'h008, 32'h0, 32'h80);
    wr(12'h00C, 8'h01);
    #1;
    chk("irq_gated", 32'(irq), 32'h0);
    rd(12'h030, 32'h4, 32'h4);
    wr(12'h00C, 8'h00);
    #1;
    chk("irq_back", 32'(irq), 32'h1);
    wr(12'h034, 8'h07);
    #1;
    chk("irq_clear", 32'(irq), 32'h0);
    // Modulo-N reloads and counts on
    wr(12'h018, h);
    wr(12'h008, 8'hC2);
    wait_irq(n);
    wr(12'h034, 8'h07);
    wait_irq(n);
    chk("modulo_period", 32'(n), 32'(h) - 32'h2);
    wr(12'h008, 8'h00);
    wr(12'h034, 8'h07);
    tdone("long");
    // Short counter timeout interrupt, then masked
    wr(12'h010, 8'h05);
    wr(12'h038, 8'h01);
    wr(12'h000, 8'h82);
    wait_irq(n);
    chk("short_period", 32'(n), 32'd6);
    rd(12'h000, 32'h20, 32'h20);
    wr(12'h038, 8'h00);
    #1;
    chk("irq_masked", 32'(irq), 32'h0);
    wr(12'h034, 8'h07);
    wr(12'h000, 8'h00);
    tdone("short");
    // Demodulation over every edge code; reserved captures nothing
    wr(12'h038, 8'h02);
    wr(12'h010, 8'hFF);
    wr(12'h014, 8'hFF);
    wr(12'h01C, 8'h12);
    wr(12'h018, 8'h34);
    for (int e = 0; e < 4; e++) begin
      wr(12'h004, 8'(8'h80 | (e << 4) | ((e % 2) << 6)));
      wr(12'h008, 8'h80);
      wr(12'h000, 8'h84);
      ir_run <= 1'b1;
      if (e < 3) begin
        wait_irq(n);
        rd(12'h030, 32'h2, 32'h2);
      end else begin
        repeat (100) @(posedge pclk);
        #1;
        chk("reserved_edge", 32'(irq), 32'h0);
      end
      if (e == 0) begin
        rd(12'h02C, 32'h80, 32'h80);
        rd(12'h028, 32'h0, 32'hFF);
        rd(12'h024, 32'h12, 32'hFF);
      end
      ir_run <= 1'b0;
      wr(12'h000, 8'h00);
      wr(12'h008, 8'h00);
      wr(12'h034, 8'h07);
    end
    tdone("demod");
    // Alternating hand-over: short pass, long pass, then software ends it
    wr(12'h010, 8'h05);
    wr(12'h018, 8'h06);
    wr(12'h01C, 8'h00);
    wr(12'h008, 8'h02);
    wr(12'h038, 8'h04);
    wr(12'h004, 8'h04);
    wr(12'h000, 8'h80);
    wait_irq(n);
    chk("pingpong_period", 32'(n), 32'd13);
    wr(12'h004, 8'h00);
    repeat (20) @(posedge pclk);
    rd(12'h008, 32'h0, 32'h80);
    rd(12'h000, 32'h0, 32'h80);
    wr(12'h034, 8'h07);
    tdone("pingpong");
    // Every combine function against forced long level and short level
    for (int i = 0; i < 16; i++) begin
      h = 8'(8'h48 | ((i % 4) << 4) | (((i / 4) % 2) << 2) | ((i / 8) << 1));
      wr(12'h004, h);
      wr(12'h000, 8'h81);
      #1;
      chk("short_pin", 32'(short_out), 32'(h[1]));
      chk("combined", 32'(comb_out), 32'(cmb(h[5:4], h[1], h[2])));
      wr(12'h000, 8'h00);
    end
    tdone("combine");
    conclude();
  end
endmodule
